// file: shared/xbp_defs.svh
/*
  Constants of the external memory bus pin block: widths, reset values,
  region windows and strobe timing.
  Assumes a 10 MHz system clock.
*/
`ifndef XBP_DEFS_SVH
`define XBP_DEFS_SVH

// ---------------------------------------------------------------
// Widths
// ---------------------------------------------------------------
`define XBP_ADDR_MSB 23
`define XBP_DATA_MSB 7
`define XBP_REGION_MSB 3
`define XBP_DEC_LSB 16

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define XBP_ADDR_RST 24'h000000
`define XBP_DATA_RST 8'h00
`define XBP_SEL_RST 4'hf

// ---------------------------------------------------------------
// Region windows on address bits 23:16, and space (1 = I/O)
// ---------------------------------------------------------------
`define XBP_REGION_LO {8'hff, 8'h40, 8'h20, 8'h00}
`define XBP_REGION_HI {8'hff, 8'hff, 8'h3f, 8'h1f}
`define XBP_REGION_IO 4'h8

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define XBP_CLK_NS 100
`define XBP_STROBE_NS 200
`define XBP_STROBE_CYC ((`XBP_STROBE_NS + `XBP_CLK_NS - 1) / `XBP_CLK_NS)

`endif

// file: shared/xbp_pkg.sv
/*
  Types of the external memory bus pin block.
  Assumes xbp_defs.svh is on the include path.
*/
`default_nettype none

package xbp_pkg;

  typedef enum logic [2:0] {
    XBP_IDLE = 3'b000,
    XBP_SETUP = 3'b001,
    XBP_STROBE = 3'b010,
    XBP_DONE = 3'b011,
    XBP_GRANT = 3'b100
  } xbp_state_type;

  typedef logic [1:0] xbp_count_type;

endpackage

`default_nettype wire

// file: design/xbp_region_decode.sv
/*
  Region select decoder: compares address bits 23:16 with four windows.
  Assumes the caller registers the result before it reaches a pin.
*/
`include "xbp_defs.svh"
`default_nettype none

module xbp_region_decode
  import xbp_pkg::*;
(
  input wire logic [`XBP_ADDR_MSB:0] addr,          // Address to decode
  input wire logic is_io,                           // High for I/O space
  input wire logic active,                          // An access is under way
  output logic [`XBP_REGION_MSB:0] sel_n            // Active-low selects
);

  localparam logic [`XBP_REGION_MSB:0][7:0] LO = `XBP_REGION_LO;
  localparam logic [`XBP_REGION_MSB:0][7:0] HI = `XBP_REGION_HI;
  localparam logic [`XBP_REGION_MSB:0] IO = `XBP_REGION_IO;

  logic [7:0] top;

  assign top = addr[`XBP_ADDR_MSB:`XBP_DEC_LSB];

  always_comb begin
    for (int i = 0; i <= `XBP_REGION_MSB; i++) begin
      sel_n[i] = ~(active && (IO[i] == is_io) && (top >= LO[i]) && (top <= HI[i]));
    end
  end

endmodule

`default_nettype wire

// file: design/xbp_bus_pins.sv
/*
  Pin-level external memory and I/O bus of the controller: address, data,
  strobes, region selects and the external-master request/grant pair.
  Assumes a core-side request port on sys_clk; pins are asynchronous and
  pass two flip-flops before use. Pad logic resolves the wires from the
  output enables.
*/
// How it works
// - Address pins are driven outward whenever the bus is not granted away.
// - During grant the address pins are released and read as inputs.
// - Address is 24 bits, bit 23 highest, in memory or I/O space.
// - The address in use feeds the region select decoder.
// - Four active-low region selects, low only for accesses inside their window.
// - Data pins driven only during our own write cycles.
// - Low request from outside: float address, data, request and strobe outputs and drive grant low.
// - Read, write and fetch strobes float during grant.
`include "xbp_defs.svh"
`default_nettype none

module xbp_bus_pins
  import xbp_pkg::*;
(
  input wire logic sys_clk,                          // System clock, 10 MHz
  input wire logic reset_n,                          // Async reset, active low
  input wire logic cpu_req,                          // Access request, held until done
  input wire logic cpu_write,                        // 1 write, 0 read
  input wire logic cpu_io,                           // 1 I/O space, 0 memory
  input wire logic cpu_fetch,                        // Instruction fetch read
  input wire logic [`XBP_ADDR_MSB:0] cpu_addr,       // Access address
  input wire logic [`XBP_DATA_MSB:0] cpu_wdata,      // Write data
  output logic cpu_ready,                            // Request can be taken
  output logic cpu_done,                             // Access complete pulse
  output logic [`XBP_DATA_MSB:0] cpu_rdata,          // Read data
  input wire logic [`XBP_ADDR_MSB:0] addr_i,         // Address pins in
  output logic [`XBP_ADDR_MSB:0] addr_o,             // Address pins out
  output logic addr_oe,                              // Address drive enable
  input wire logic [`XBP_DATA_MSB:0] data_i,         // Data pins in
  output logic [`XBP_DATA_MSB:0] data_o,             // Data pins out
  output logic data_oe,                              // Data drive enable
  input wire logic mem_req_n_i,                      // Memory request pin in
  input wire logic io_req_n_i,                       // I/O request pin in
  output logic mem_req_n_o,                          // Memory request pin out
  output logic io_req_n_o,                           // I/O request pin out
  output logic req_oe,                               // Request pins drive enable
  output logic rd_n_o,                               // Read strobe
  output logic wr_n_o,                               // Write strobe
  output logic fetch_n_o,                            // Fetch indicator
  output logic strobe_oe,                            // Strobe drive enable
  input wire logic wait_n,                           // Wait input, active low
  input wire logic ext_master_request_n,             // Outside master request
  output logic ext_master_grant_n,                   // Grant to outside master
  output logic region_select_0_n,                    // Region 0 select
  output logic region_select_1_n,                    // Region 1 select
  output logic region_select_2_n,                    // Region 2 select
  output logic region_select_3_n                     // Region 3 select
);

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [1:0] breq_sync_reg, wait_sync_reg, mreq_sync_reg, ioreq_sync_reg;
  logic [1:0][`XBP_ADDR_MSB:0] ain_sync_reg;
  logic [1:0][`XBP_DATA_MSB:0] din_sync_reg;
  logic breq_n, wait_low, ext_mreq_n, ext_ioreq_n;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      breq_sync_reg <= 2'h3;
      wait_sync_reg <= 2'h3;
      mreq_sync_reg <= 2'h3;
      ioreq_sync_reg <= 2'h3;
      ain_sync_reg <= '0;
      din_sync_reg <= '0;
    end else begin
      breq_sync_reg <= {breq_sync_reg[0], ext_master_request_n};
      wait_sync_reg <= {wait_sync_reg[0], wait_n};
      mreq_sync_reg <= {mreq_sync_reg[0], mem_req_n_i};
      ioreq_sync_reg <= {ioreq_sync_reg[0], io_req_n_i};
      ain_sync_reg <= {ain_sync_reg[0], addr_i};
      din_sync_reg <= {din_sync_reg[0], data_i};
    end
  end

  assign breq_n = breq_sync_reg[1];
  assign wait_low = ~wait_sync_reg[1];
  assign ext_mreq_n = mreq_sync_reg[1];
  assign ext_ioreq_n = ioreq_sync_reg[1];

  // ---------------------------------------------------------------
  // Access sequencer
  // ---------------------------------------------------------------
  xbp_state_type state_reg, state_next;
  xbp_count_type cnt_reg, cnt_next;
  logic [`XBP_ADDR_MSB:0] addr_reg, addr_next;
  logic [`XBP_DATA_MSB:0] wdata_reg, wdata_next, rdata_reg, rdata_next;
  logic write_reg, write_next, io_reg, io_next, fetch_reg, fetch_next;
  logic done_reg, done_next;

  assign cpu_ready = (state_reg == XBP_IDLE) && breq_n;

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    addr_next = addr_reg;
    wdata_next = wdata_reg;
    rdata_next = rdata_reg;
    write_next = write_reg;
    io_next = io_reg;
    fetch_next = fetch_reg;
    done_next = 1'b0;
    unique case (state_reg)
      XBP_IDLE: begin
        if (!breq_n) begin
          state_next = XBP_GRANT;
        end else if (cpu_req) begin
          state_next = XBP_SETUP;
          addr_next = cpu_addr;
          wdata_next = cpu_wdata;
          write_next = cpu_write;
          io_next = cpu_io;
          fetch_next = cpu_fetch & ~cpu_write & ~cpu_io;
        end
      end
      XBP_SETUP: begin
        state_next = XBP_STROBE;
        cnt_next = 2'(`XBP_STROBE_CYC - 1);
      end
      XBP_STROBE: begin
        if (cnt_reg != 2'h0) begin
          cnt_next = cnt_reg - 2'h1;
        end else if (!wait_low) begin
          state_next = XBP_DONE;
        end
      end
      XBP_DONE: begin
        state_next = XBP_IDLE;
        done_next = 1'b1;
        if (!write_reg) begin
          rdata_next = din_sync_reg[1];
        end
      end
      XBP_GRANT: begin
        if (breq_n) begin
          state_next = XBP_IDLE;
        end
      end
      default: begin
        state_next = XBP_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= XBP_IDLE;
      cnt_reg <= 2'h0;
      addr_reg <= `XBP_ADDR_RST;
      wdata_reg <= `XBP_DATA_RST;
      rdata_reg <= `XBP_DATA_RST;
      write_reg <= 1'b0;
      io_reg <= 1'b0;
      fetch_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      addr_reg <= addr_next;
      wdata_reg <= wdata_next;
      rdata_reg <= rdata_next;
      write_reg <= write_next;
      io_reg <= io_next;
      fetch_reg <= fetch_next;
      done_reg <= done_next;
    end
  end

  assign cpu_done = done_reg;
  assign cpu_rdata = rdata_reg;

  // ---------------------------------------------------------------
  // Pin drivers
  // ---------------------------------------------------------------
  logic in_access, granted;

  assign in_access = (state_reg != XBP_IDLE) && (state_reg != XBP_GRANT);
  assign granted = (state_reg == XBP_GRANT);

  assign addr_o = addr_reg;
  assign addr_oe = ~granted;
  assign data_o = wdata_reg;
  assign data_oe = write_reg && ((state_reg == XBP_STROBE) || (state_reg == XBP_DONE));
  assign req_oe = ~granted;
  assign strobe_oe = ~granted;
  assign ext_master_grant_n = ~granted;
  assign mem_req_n_o = ~(in_access && !io_reg);
  assign io_req_n_o = ~(in_access && io_reg);
  assign rd_n_o = ~(!write_reg && (state_reg == XBP_STROBE));
  assign wr_n_o = ~(write_reg && (state_reg == XBP_STROBE));
  assign fetch_n_o = ~(fetch_reg && (state_reg == XBP_STROBE));

  // ---------------------------------------------------------------
  // Region selects
  // ---------------------------------------------------------------
  logic [`XBP_ADDR_MSB:0] dec_addr;
  logic dec_io, dec_active;
  logic [`XBP_REGION_MSB:0] dec_sel_n, sel_reg, sel_next;

  // decoder follows the address in use
  always_comb begin
    dec_addr = granted ? ain_sync_reg[1] : addr_reg;
    dec_io = granted ? ~ext_ioreq_n : io_reg;
    dec_active = granted ? (~ext_mreq_n | ~ext_ioreq_n) : in_access;
    sel_next = dec_sel_n;
  end

  xbp_region_decode u_decode (
    .addr(dec_addr),
    .is_io(dec_io),
    .active(dec_active),
    .sel_n(dec_sel_n)
  );

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sel_reg <= `XBP_SEL_RST;
    end else begin
      sel_reg <= sel_next;
    end
  end

  assign region_select_0_n = sel_reg[0];
  assign region_select_1_n = sel_reg[1];
  assign region_select_2_n = sel_reg[2];
  assign region_select_3_n = sel_reg[3];

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  AST_ADDR_DRIVEN: assert property (state_reg != XBP_GRANT |-> addr_oe)
    else $error("address not driven outside grant");
  AST_ADDR_RELEASED: assert property (ext_master_grant_n == 1'b0 |-> !addr_oe)
    else $error("address driven during grant");
  AST_ADDR_HELD: assert property ($rose(in_access) |=> $stable(addr_o) [*2])
    else $error("address moved during access");
  AST_SEL_FOLLOWS: assert property (
    in_access && !io_reg && addr_reg[23:16] <= 8'h1f |=> !region_select_0_n)
    else $error("region 0 not selected");
  AST_SEL_IDLE: assert property (
    state_reg == XBP_IDLE && $past(state_reg) == XBP_IDLE |=> sel_reg == 4'hf)
    else $error("region select low when idle");
  AST_DATA_WRITE_ONLY: assert property (data_oe |-> write_reg && !granted)
    else $error("data driven outside own write");
  AST_GRANT_TIME: assert property (
    state_reg == XBP_IDLE && !breq_n |=> !ext_master_grant_n && !req_oe)
    else $error("request not granted next cycle");
  AST_STROBE_FLOAT: assert property (!ext_master_grant_n |-> !strobe_oe)
    else $error("strobes driven during grant");
  AST_WAIT_STRETCH: assert property (
    state_reg == XBP_STROBE && cnt_reg == 2'h0 && wait_low |=> state_reg == XBP_STROBE)
    else $error("wait not honoured");
  AST_DONE_BOUND: assert property (
    state_reg == XBP_SETUP ##2 !wait_low |-> ##2 cpu_done)
    else $error("access length wrong");

  COV_READ: cover property (state_reg == XBP_DONE && !write_reg);
  COV_WRITE: cover property (state_reg == XBP_DONE && write_reg);
  COV_WAIT: cover property (state_reg == XBP_STROBE && wait_low && cnt_reg == 2'h0);
  COV_GRANT: cover property ($fell(ext_master_grant_n));

endmodule

`default_nettype wire

// file: tb/xbp_mem_model.sv
/*
  Behavioural external memory facing the bus pins: answers reads with a
  byte made from the address, stores writes, can hold wait low.
  Assumes the bench resolves the data wire from the controller's drive enable.
*/
`include "xbp_defs.svh"
`default_nettype none

module xbp_mem_model
  import xbp_pkg::*;
(
  input wire logic sys_clk, // System clock
  input wire logic [`XBP_ADDR_MSB:0] addr, // Address pins
  input wire logic [`XBP_DATA_MSB:0] wdata, // Data from controller
  input wire logic data_oe, // Controller drives data
  input wire logic rd_n, // Read strobe
  input wire logic wr_n, // Write strobe
  input wire logic strobe_oe, // Strobes driven
  input wire logic [3:0] wait_cyc, // Wait cycles per access
  output logic [`XBP_DATA_MSB:0] rdata, // Byte the memory drives
  output logic wait_n, // Wait request
  output logic [`XBP_DATA_MSB:0] last_write // Last byte written
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] last_rd = 8'h00;
  logic [3:0] cnt = 4'h0;
  logic active;

  assign active = strobe_oe && !(rd_n && wr_n);
  // Released data shows the inverse of the last byte, never a held value
  assign rdata = (strobe_oe && !rd_n) ? (addr[7:0] ^ 8'ha5) : ~last_rd;
  // slow device wait
  // Held low from before the strobe so the synchronised pin is seen in time
  assign wait_n = !(wait_cyc != 4'h0 && cnt < wait_cyc);

  always @(posedge sys_clk) begin
    if (strobe_oe && !rd_n) last_rd <= addr[7:0] ^ 8'ha5;
    if (active && !wr_n && data_oe) last_write <= wdata;
    cnt <= active ? cnt + 4'h1 : 4'h0;
  end
endmodule

`default_nettype wire

// file: tb/tb.sv
/*
  Self-checking bench of the bus pin block with a memory model and an
  outside master driven by the bench.
  Assumes xbp_defs.svh on the include path.
*/
`include "xbp_defs.svh"
`default_nettype none

module tb
  import xbp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0, reset_n, cpu_req, cpu_write, cpu_io, cpu_fetch;
  logic [23:0] cpu_addr, addr_i, addr_o, ext_addr;
  logic [7:0] cpu_wdata, cpu_rdata, data_i, data_o, mem_rdata, last_write;
  logic cpu_ready, cpu_done, addr_oe, data_oe, req_oe, strobe_oe, wait_n;
  logic mem_req_n_i, io_req_n_i, mem_req_n_o, io_req_n_o, ext_mreq;
  logic rd_n_o, wr_n_o, fetch_n_o, ext_master_request_n, ext_master_grant_n;
  logic region_select_0_n, region_select_1_n, region_select_2_n, region_select_3_n;
  logic [3:0] wait_cyc, sel_n;
  int n_errors = 0, comparisons = 0, nominal;

  always #50 sys_clk = ~sys_clk;
  assign sel_n = {region_select_3_n, region_select_2_n, region_select_1_n, region_select_0_n};
  assign addr_i = addr_oe ? addr_o : ext_addr;
  assign data_i = data_oe ? data_o : mem_rdata;
  assign mem_req_n_i = req_oe ? mem_req_n_o : ext_mreq;
  assign io_req_n_i = req_oe ? io_req_n_o : 1'b1;

  xbp_bus_pins u_xbp_bus_pins (.sys_clk(sys_clk), .reset_n(reset_n), .cpu_req(cpu_req),
    .cpu_write(cpu_write), .cpu_io(cpu_io), .cpu_fetch(cpu_fetch), .cpu_addr(cpu_addr),
    .cpu_wdata(cpu_wdata), .cpu_ready(cpu_ready), .cpu_done(cpu_done),
    .cpu_rdata(cpu_rdata), .addr_i(addr_i), .addr_o(addr_o), .addr_oe(addr_oe),
    .data_i(data_i), .data_o(data_o), .data_oe(data_oe), .mem_req_n_i(mem_req_n_i),
    .io_req_n_i(io_req_n_i), .mem_req_n_o(mem_req_n_o), .io_req_n_o(io_req_n_o),
    .req_oe(req_oe), .rd_n_o(rd_n_o), .wr_n_o(wr_n_o), .fetch_n_o(fetch_n_o),
    .strobe_oe(strobe_oe), .wait_n(wait_n), .ext_master_request_n(ext_master_request_n),
    .ext_master_grant_n(ext_master_grant_n), .region_select_0_n(region_select_0_n),
    .region_select_1_n(region_select_1_n), .region_select_2_n(region_select_2_n),
    .region_select_3_n(region_select_3_n));

  xbp_mem_model u_xbp_mem_model (.sys_clk(sys_clk), .addr(addr_o), .wdata(data_o),
    .data_oe(data_oe), .rd_n(rd_n_o), .wr_n(wr_n_o), .strobe_oe(strobe_oe),
    .wait_cyc(wait_cyc), .rdata(mem_rdata), .wait_n(wait_n), .last_write(last_write));

  task automatic tick();
    @(posedge sys_clk);
    #1;
  endtask

  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic tally_and_finish();
    if (n_errors == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    chk("addr_oe", 1'b1, addr_oe);
    chk("data_oe", 1'b0, data_oe);
    chk("grant_n", 1'b1, ext_master_grant_n);
    chk("selects", 4'hf, sel_n);
    chk("strobes", 4'hf, {strobe_oe, rd_n_o, wr_n_o, fetch_n_o});
  endtask

  task automatic access(input logic wr, io, fe, input logic [23:0] a, input logic [7:0] d,
                        input logic [3:0] esel, output int n);
    logic [3:0] seen;
    logic rd_drive, fseen, aoe_low;
    logic [1:0] sp;
    sp = 2'h0;
    seen = 4'hf;
    rd_drive = 1'b0;
    fseen = 1'b0;
    aoe_low = 1'b0;
    n = 0;
    while (!cpu_ready && n < 20) begin
      tick();
      n++;
    end
    {cpu_req, cpu_write, cpu_io, cpu_fetch, cpu_addr, cpu_wdata} = {1'b1, wr, io, fe, a, d};
    n = 0;
    do begin
      tick();
      n++;
      seen &= sel_n;
      if (!wr && data_oe) rd_drive = 1'b1;
      if (!fetch_n_o) fseen = 1'b1;
      if (!addr_oe) aoe_low = 1'b1;
      if (!mem_req_n_o) sp[0] = 1'b1;
      if (!io_req_n_o) sp[1] = 1'b1;
    end while (cpu_done !== 1'b1 && n < 50);
    cpu_req = 1'b0;
    chk("selects in access", esel, seen);
    chk("addr_o", a, addr_o);
    chk("space", {io, ~io}, sp);
    chk("addr_oe low", 1'b0, aoe_low);
    chk("data_oe in read", 1'b0, rd_drive);
    chk("fetch", fe, fseen);
    if (wr) chk("written", d, last_write);
    else chk("rdata", a[7:0] ^ 8'ha5, cpu_rdata);
    tick();
    tick();
    chk("selects idle", 4'hf, sel_n);
  endtask

  task automatic t_regions();
    int n;
    access(1'b0, 1'b0, 1'b0, 24'h1fffc3, 8'h00, 4'he, nominal);
    access(1'b1, 1'b0, 1'b0, 24'h200011, 8'h3c, 4'hd, n);
    access(1'b0, 1'b0, 1'b1, 24'h3f1234, 8'h00, 4'hd, n);
    access(1'b1, 1'b0, 1'b0, 24'h400042, 8'hc3, 4'hb, n);
    access(1'b0, 1'b0, 1'b0, 24'hff0a0b, 8'h00, 4'hb, n);
    access(1'b1, 1'b1, 1'b0, 24'hff0077, 8'h5a, 4'h7, n);
    access(1'b0, 1'b1, 1'b0, 24'h100010, 8'h00, 4'hf, n);
  endtask

  task automatic t_wait();
    int n;
    wait_cyc = 4'h4;
    access(1'b0, 1'b0, 1'b0, 24'h0000e1, 8'h00, 4'he, n);
    chk("stretched", 1'b1, n > nominal);
    wait_cyc = 4'h0;
  endtask

  task automatic t_grant();
    int k;
    k = 0;
    ext_addr = 24'h250100;
    ext_mreq = 1'b0;
    ext_master_request_n = 1'b0;
    while (ext_master_grant_n !== 1'b0 && k < 10) begin
      tick();
      k++;
    end
    chk("grant_n", 1'b0, ext_master_grant_n);
    chk("addr_oe grant", 1'b0, addr_oe);
    chk("data_oe grant", 1'b0, data_oe);
    chk("strobe_oe grant", 1'b0, strobe_oe);
    chk("req_oe grant", 1'b0, req_oe);
    cpu_req = 1'b1;
    repeat (4) tick();
    chk("ready grant", 1'b0, cpu_ready);
    chk("selects ext", 4'hd, sel_n);
    cpu_req = 1'b0;
    ext_master_request_n = 1'b1;
    ext_mreq = 1'b1;
    k = 0;
    while (ext_master_grant_n !== 1'b1 && k < 10) begin
      tick();
      k++;
    end
    chk("addr_oe back", 1'b1, addr_oe);
    chk("strobe_oe back", 1'b1, strobe_oe);
  endtask

  initial begin
    #1_000_000;
    n_errors++;
    tally_and_finish();
  end

  initial begin
    {reset_n, cpu_req, cpu_write, cpu_io, cpu_fetch, cpu_addr, cpu_wdata} = '0;
    {ext_master_request_n, ext_mreq, ext_addr, wait_cyc} = {2'b11, 24'h000000, 4'h0};
    repeat (20) @(posedge sys_clk);
    #1;
    reset_n = 1'b1;
    t_reset();
    t_regions();
    t_wait();
    t_grant();
    tally_and_finish();
  end
endmodule

`default_nettype wire
